// *** src/hbsd_consts.svh ***
// Purpose: Shared constants of the host bus strobe decoder
// Assumes: Included by bare name from hbsd_irq, hbsd_top, hbsd_top_props and host_bus_strobe_decode_tb
// Notes:   Definitions only
`ifndef HBSD_CONSTS_SVH
`define HBSD_CONSTS_SVH

// APB register offsets
`define HBSD_OFF_CTRL       8'h00
`define HBSD_OFF_STATUS     8'h04
`define HBSD_OFF_MASK       8'h08
`define HBSD_OFF_STRAPS     8'h0c
`define HBSD_OFF_ADDR       8'h10
`define HBSD_OFF_WDATA      8'h14

// Control register fields and reset value
`define HBSD_CTRL_POL_BIT   0
`define HBSD_CTRL_EDGE_BIT  1
`define HBSD_CTRL_W         2
`define HBSD_CTRL_RST       2'h0

// Status and mask register fields
`define HBSD_ST_ADDR        0
`define HBSD_ST_WRITE       1
`define HBSD_ST_READ        2
`define HBSD_ST_CORE        3
`define HBSD_ST_W           4
`define HBSD_MASK_RST       4'h0

// Strap readback fields
`define HBSD_SP_STYLE       0
`define HBSD_SP_PHASE       1
`define HBSD_SP_TOPO        2

// Strap encodings
`define HBSD_STYLE_DIR_DS   1'b0
`define HBSD_STYLE_RD_WR    1'b1
`define HBSD_PHASE_LATCH    1'b0
`define HBSD_PHASE_SELECT   1'b1
`define HBSD_TOPO_SPLIT     1'b0
`define HBSD_TOPO_GENERIC   1'b1

// Timing
`define HBSD_CLK_PERIOD_NS  5
`define HBSD_INT_PULSE_NS   40
`define HBSD_INT_PULSE_CYC  ((`HBSD_INT_PULSE_NS + `HBSD_CLK_PERIOD_NS - 1) / `HBSD_CLK_PERIOD_NS)
`define HBSD_BUSY_NS        30
`define HBSD_BUSY_CYC       ((`HBSD_BUSY_NS + `HBSD_CLK_PERIOD_NS - 1) / `HBSD_CLK_PERIOD_NS)
`define HBSD_STRAP_SETTLE   2'h3
`define HBSD_INT_IDLE_RST   1'b1

`endif

// *** src/hbsd_pkg.sv ***
// Purpose: Types of the host bus strobe decoder
// Assumes: Nothing
// Notes:   Constants live in hbsd_consts.svh
package hbsd_pkg;

  // Host access tracking, one-hot
  typedef enum logic [2:0] {
    HBSD_ACC_IDLE = 3'b001,
    HBSD_ACC_HOLD = 3'b010,
    HBSD_ACC_WAIT = 3'b100
  } hbsd_acc_e;

endpackage

// *** src/hbsd_sync.sv ***
// Purpose: Two flip-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous to i_clock
// Notes:   Only the second stage is visible outside
`timescale 1ns/1ps
`default_nettype none
module hbsd_sync #(
  parameter int             W   = 1,
  parameter logic [W-1:0]   RST = '0
) (
  // Clock and reset
  input  wire logic         i_clock,
  input  wire logic         i_rst_b,
  // Data
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_reg;

  // Two stage capture
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_reg <= RST;
      o_sync   <= RST;
    end else begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end

endmodule // hbsd_sync
`default_nettype wire

// *** src/hbsd_irq.sv ***
// Purpose: Host interrupt pin driver with programmable polarity and form
// Assumes: i_pending is a level from logic on i_clock
// Notes:   Edge form gives a fixed-width pulse per rising pending
`timescale 1ns/1ps
`default_nettype none
`include "hbsd_consts.svh"
module hbsd_irq (
  // Clock and reset
  input  wire logic i_clock,
  input  wire logic i_rst_b,
  // Control
  input  wire logic i_pending,
  input  wire logic i_active_high,
  input  wire logic i_edge_mode,
  // Pin
  output logic      o_int
);

  logic       pend_d_reg;
  logic [3:0] pulse_cnt_reg;
  logic       assert_now;

  // Pulse timer started on each new pending condition
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pend_d_reg    <= 1'b0;
      pulse_cnt_reg <= 4'h0;
    end else begin
      pend_d_reg <= i_pending;
      if (i_pending && !pend_d_reg) begin
        pulse_cnt_reg <= 4'(`HBSD_INT_PULSE_CYC);
      end else if (pulse_cnt_reg != 4'h0) begin
        pulse_cnt_reg <= pulse_cnt_reg - 4'h1;
      end
    end
  end

  // Edge form uses the pulse, level form the pending level
  assign assert_now = i_edge_mode ? (pulse_cnt_reg != 4'h0) : i_pending;

  // Polarity applied in the output flop
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_int <= `HBSD_INT_IDLE_RST;
    end else begin
      o_int <= i_active_high ? assert_now : !assert_now;
    end
  end

endmodule // hbsd_irq
`default_nettype wire

// *** src/hbsd_top.sv ***
// Purpose: Front end of the parallel host port: strobe decode, address
//          phase handling, ready and host interrupt, with APB registers
// Assumes: All host pins are asynchronous; APB and core on i_clock
// Notes:   Straps are captured once, shortly after reset release
// What this block does
// - Strobe-style strap picks dir/strobe or read/write
// - Address-phase strap picks latch strobe or select
// - Latch strobe falling edge captures bus address, split bus only
// - Select high at write end means address
// - Select low at write end means data
// - Select behaviour only in split-bus configuration
// - Interrupt pin polarity and edge/level programmable
// - Split bus: 8-bit multiplexed register access
// - Generic: address bus plus 16-bit data
// - Ready low while previous access still busy
`timescale 1ns/1ps
`default_nettype none
`include "hbsd_consts.svh"
module hbsd_top
  import hbsd_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_b,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Host pins
  input  wire logic        i_cs_n,
  input  wire logic        i_dir_rd_n,
  input  wire logic        i_data_strobe_wr_n,
  input  wire logic        i_ale_addr_data_select,
  input  wire logic [7:0]  i_ad,
  input  wire logic [15:0] i_data,
  input  wire logic        i_ready_in,
  output logic             o_ready,
  output logic             o_ready_oe,
  output logic             o_int,
  // Power-up straps
  input  wire logic        i_strobe_style_strap,
  input  wire logic        i_address_phase_strap,
  input  wire logic        i_bus_topology_strap,
  // Core side
  output logic      [7:0]  o_reg_addr,
  output logic      [15:0] o_reg_wdata,
  output logic             o_reg_wide,
  output logic             o_reg_wr,
  output logic             o_reg_rd,
  input  wire logic        i_core_busy,
  input  wire logic        i_core_irq
);

  // Returns {read_active, write_active} for one set of pin levels
  function automatic logic [1:0] hbsd_decode(input logic style, input logic cs_n,
                                             input logic p26, input logic p27);
    logic sel;
    logic rd;
    logic wr;
    sel = !cs_n;
    if (style == `HBSD_STYLE_DIR_DS) begin
      rd = sel && !p27 && p26;
      wr = sel && !p27 && !p26;
    end else begin
      rd = sel && !p26;
      wr = sel && !p27;
    end
    return {rd, wr};
  endfunction

  // Synchronised pins
  logic        cs_n_s;
  logic        p26_s;
  logic        p27_s;
  logic        ale_s;
  logic [7:0]  ad_s;
  logic [15:0] data_s;
  logic [2:0]  straps_s;
  logic        ready_in_s;

  // Previous synchronised levels
  logic        cs_n_d_reg;
  logic        p26_d_reg;
  logic        p27_d_reg;
  logic        ale_d_reg;
  logic [7:0]  ad_d_reg;
  logic [15:0] data_d_reg;

  // Captured straps
  logic [1:0]  strap_cnt_reg;
  logic        strap_ok_reg;
  logic        style_reg;
  logic        phase_reg;
  logic        topo_reg;

  // Decoded host events
  logic [1:0]  act_now;
  logic [1:0]  act_prev;
  logic        rd_start;
  logic        wr_end;
  logic        ale_fall;
  logic        split_mode;
  logic        sel_mode;
  logic        addr_ev;
  logic        data_ev;

  // Registers and access state
  logic [`HBSD_CTRL_W-1:0] ctrl_reg;
  logic [`HBSD_ST_W-1:0]   status_reg;
  logic [`HBSD_ST_W-1:0]   mask_reg;
  logic [`HBSD_ST_W-1:0]   status_set;
  logic [7:0]              addr_reg;
  logic [15:0]             wdata_reg;
  hbsd_acc_e               acc_reg;
  hbsd_acc_e               acc_next;
  logic [3:0]              busy_cnt_reg;
  logic                    apb_wr;
  logic                    apb_rd;
  logic [31:0]             rdata_next;
  logic                    err_next;

  // Pin synchronisers; strobes idle high
  hbsd_sync #(.W(4), .RST(4'hf)) u_sync_ctl (
    .i_clock (i_clock),
    .i_rst_b (i_rst_b),
    .i_async ({i_cs_n, i_dir_rd_n, i_data_strobe_wr_n, i_ready_in}),
    .o_sync  ({cs_n_s, p26_s, p27_s, ready_in_s})
  );

  hbsd_sync #(.W(28), .RST(28'h0)) u_sync_dat (
    .i_clock (i_clock),
    .i_rst_b (i_rst_b),
    .i_async ({i_ale_addr_data_select, i_ad, i_data, i_strobe_style_strap,
               i_address_phase_strap, i_bus_topology_strap}),
    .o_sync  ({ale_s, ad_s, data_s, straps_s})
  );

  // Delayed copies for edge detection
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cs_n_d_reg <= 1'b1;
      p26_d_reg  <= 1'b1;
      p27_d_reg  <= 1'b1;
      ale_d_reg  <= 1'b0;
      ad_d_reg   <= 8'h00;
      data_d_reg <= 16'h0000;
    end else begin
      cs_n_d_reg <= cs_n_s;
      p26_d_reg  <= p26_s;
      p27_d_reg  <= p27_s;
      ale_d_reg  <= ale_s;
      ad_d_reg   <= ad_s;
      data_d_reg <= data_s;
    end
  end

  // Straps taken once after the synchronisers have settled
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      strap_cnt_reg <= 2'h0;
      strap_ok_reg  <= 1'b0;
      style_reg     <= `HBSD_STYLE_DIR_DS;
      phase_reg     <= `HBSD_PHASE_LATCH;
      topo_reg      <= `HBSD_TOPO_SPLIT;
    end else if (!strap_ok_reg) begin
      if (strap_cnt_reg == `HBSD_STRAP_SETTLE) begin
        strap_ok_reg <= 1'b1;
        style_reg    <= straps_s[2];
        phase_reg    <= straps_s[1];
        topo_reg     <= straps_s[0];
      end else begin
        strap_cnt_reg <= strap_cnt_reg + 2'h1;
      end
    end
  end

  // Strobe decoding and edges
  assign act_now    = hbsd_decode(style_reg, cs_n_s, p26_s, p27_s);
  assign act_prev   = hbsd_decode(style_reg, cs_n_d_reg, p26_d_reg, p27_d_reg);
  assign rd_start   = strap_ok_reg && act_now[1] && !act_prev[1];
  assign wr_end     = strap_ok_reg && act_prev[0] && !act_now[0];
  assign split_mode = (topo_reg == `HBSD_TOPO_SPLIT);
  assign sel_mode   = split_mode && (phase_reg == `HBSD_PHASE_SELECT);

  // Falling latch strobe, only with chip select low
  assign ale_fall = strap_ok_reg && split_mode && (phase_reg == `HBSD_PHASE_LATCH)
                    && ale_d_reg && !ale_s && !cs_n_s;

  // Address qualification at latch fall or write end, data at the end of a write
  assign addr_ev = ale_fall || (wr_end && sel_mode && ale_d_reg);
  assign data_ev = wr_end && !(sel_mode && ale_d_reg);

  // Captured address and write data
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      addr_reg  <= 8'h00;
      wdata_reg <= 16'h0000;
    end else if (ale_fall) begin
      addr_reg <= ad_d_reg;
    end else if (wr_end) begin
      if (!split_mode) begin
        addr_reg  <= ad_d_reg;
        wdata_reg <= data_d_reg;
      end else if (sel_mode && ale_d_reg) begin
        addr_reg <= ad_d_reg;
      end else begin
        wdata_reg <= {8'h00, ad_d_reg};
      end
    end else if (rd_start && !split_mode) begin
      addr_reg <= ad_s;
    end
  end

  // Core-side request strobes
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_reg_wr    <= 1'b0;
      o_reg_rd    <= 1'b0;
      o_reg_addr  <= 8'h00;
      o_reg_wdata <= 16'h0000;
      o_reg_wide  <= 1'b0;
    end else begin
      o_reg_wr   <= data_ev;
      o_reg_rd   <= rd_start;
      o_reg_wide <= !split_mode;
      if (data_ev) begin
        o_reg_addr  <= split_mode ? addr_reg : ad_d_reg;
        o_reg_wdata <= split_mode ? {8'h00, ad_d_reg} : data_d_reg;
      end else if (rd_start) begin
        o_reg_addr <= split_mode ? addr_reg : ad_s;
      end
    end
  end

  // Ready tracking: hold a minimum time, then wait for the core
  always_comb begin
    acc_next = acc_reg;
    case (acc_reg)
      HBSD_ACC_IDLE: begin
        if (data_ev || rd_start) begin
          acc_next = HBSD_ACC_HOLD;
        end
      end
      HBSD_ACC_HOLD: begin
        if (busy_cnt_reg == 4'h1) begin
          acc_next = HBSD_ACC_WAIT;
        end
      end
      HBSD_ACC_WAIT: begin
        if (!i_core_busy) begin
          acc_next = HBSD_ACC_IDLE;
        end
      end
      default: begin
        acc_next = HBSD_ACC_IDLE;
      end
    endcase
  end

  // Access state and hold counter
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      acc_reg      <= HBSD_ACC_IDLE;
      busy_cnt_reg <= 4'h0;
    end else begin
      acc_reg <= acc_next;
      if (acc_reg == HBSD_ACC_IDLE && acc_next == HBSD_ACC_HOLD) begin
        busy_cnt_reg <= 4'(`HBSD_BUSY_CYC);
      end else if (busy_cnt_reg != 4'h0) begin
        busy_cnt_reg <= busy_cnt_reg - 4'h1;
      end
    end
  end

  // Ready pin driven only in generic configuration
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_ready    <= 1'b0;
      o_ready_oe <= 1'b0;
    end else begin
      o_ready    <= strap_ok_reg && (acc_next == HBSD_ACC_IDLE) && !i_core_busy;
      o_ready_oe <= strap_ok_reg && !split_mode;
    end
  end

  // APB strobes
  assign apb_wr = i_psel && i_penable && o_pready && i_pwrite;
  assign apb_rd = i_psel && !i_penable && !i_pwrite;

  // Sticky event sources
  assign status_set = {i_core_irq, rd_start, data_ev, addr_ev};

  // Control and mask registers
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_reg <= `HBSD_CTRL_RST;
      mask_reg <= `HBSD_MASK_RST;
    end else if (apb_wr) begin
      if (i_paddr == `HBSD_OFF_CTRL) begin
        ctrl_reg <= i_pwdata[`HBSD_CTRL_W-1:0];
      end else if (i_paddr == `HBSD_OFF_MASK) begin
        mask_reg <= i_pwdata[`HBSD_ST_W-1:0];
      end
    end
  end

  // Status: write one to clear, a new event wins over the clear
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      status_reg <= {`HBSD_ST_W{1'b0}};
    end else if (apb_wr && i_paddr == `HBSD_OFF_STATUS) begin
      status_reg <= (status_reg & ~i_pwdata[`HBSD_ST_W-1:0]) | status_set;
    end else begin
      status_reg <= status_reg | status_set;
    end
  end

  // Read mux and unmapped detection
  always_comb begin
    rdata_next = 32'h0000_0000;
    err_next   = 1'b0;
    if (i_paddr == `HBSD_OFF_CTRL) begin
      rdata_next[`HBSD_CTRL_W-1:0] = ctrl_reg;
    end else if (i_paddr == `HBSD_OFF_STATUS) begin
      rdata_next[`HBSD_ST_W-1:0] = status_reg;
    end else if (i_paddr == `HBSD_OFF_MASK) begin
      rdata_next[`HBSD_ST_W-1:0] = mask_reg;
    end else if (i_paddr == `HBSD_OFF_STRAPS) begin
      rdata_next[`HBSD_SP_STYLE] = style_reg;
      rdata_next[`HBSD_SP_PHASE] = phase_reg;
      rdata_next[`HBSD_SP_TOPO]  = topo_reg;
    end else if (i_paddr == `HBSD_OFF_ADDR) begin
      rdata_next[7:0] = addr_reg;
    end else if (i_paddr == `HBSD_OFF_WDATA) begin
      rdata_next[15:0] = wdata_reg;
    end else begin
      err_next = 1'b1;
    end
  end

  // APB answer: ready in the first access cycle
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end else if (i_psel && !i_penable) begin
      o_pready  <= 1'b1;
      o_pslverr <= err_next;
      o_prdata  <= apb_rd ? rdata_next : 32'h0000_0000;
    end else begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end
  end

  // Host interrupt pin
  hbsd_irq u_irq (
    .i_clock       (i_clock),
    .i_rst_b       (i_rst_b),
    .i_pending     (|(status_reg & mask_reg)),
    .i_active_high (ctrl_reg[`HBSD_CTRL_POL_BIT]),
    .i_edge_mode   (ctrl_reg[`HBSD_CTRL_EDGE_BIT]),
    .o_int         (o_int)
  );

endmodule // hbsd_top
`default_nettype wire

// *** testbench/hbsd_host_model.sv ***
// Purpose: Host bus master model on the parallel host pins
// Assumes: The bench calls one task at a time; ready is resolved
// Notes:   Released bus pins show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module hbsd_host_model (
  // Clock and ready pin
  input  wire logic        i_clock,
  input  wire logic        i_ready,
  // Host pins
  output logic             o_cs_n,
  output logic             o_dir_rd_n,
  output logic             o_strobe_wr_n,
  output logic             o_ale_sel,
  output logic [7:0]       o_ad,
  output logic [15:0]      o_data,
  output logic             o_late
);
  // Idle pins at time zero
  initial begin
    o_cs_n     = 1'b1;
    o_dir_rd_n = 1'b1;
    o_strobe_wr_n = 1'b1;
    o_ale_sel  = 1'b0;
    o_ad       = 8'h00;
    o_data     = 16'h0000;
    o_late     = 1'b0;
  end
  // Hold, release the bus, then wait for ready under a bound
  task automatic release_bus(input logic [7:0] a, input logic [15:0] d);
    repeat (3) @(posedge i_clock);
    o_cs_n    <= 1'b1;
    o_ale_sel <= 1'b0;
    o_ad      <= ~a;
    o_data    <= ~d;
    repeat (6) @(posedge i_clock);
    for (int n = 0; n < 60 && i_ready !== 1'b1; n++) @(posedge i_clock);
    if (i_ready !== 1'b1) o_late <= 1'b1;
  endtask
  // One read or write; style 1 has separate read and write strobes
  task automatic acc(input logic cs_n, input logic rd, input logic sty, input logic sel,
                     input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clock);
    o_cs_n     <= cs_n;
    o_ad       <= a;
    o_data     <= d;
    o_ale_sel  <= sel;
    o_dir_rd_n <= sty | rd;
    @(posedge i_clock);
    if (sty && rd) o_dir_rd_n <= 1'b0;
    else o_strobe_wr_n <= 1'b0;
    repeat (3) @(posedge i_clock);
    o_dir_rd_n <= sty | rd;
    o_strobe_wr_n <= 1'b1;
    release_bus(a, d);
  endtask
  // Address latch phase; address stands before the falling edge
  task automatic ale(input logic [7:0] a);
    @(posedge i_clock);
    o_cs_n    <= 1'b0;
    o_ad      <= a;
    o_ale_sel <= 1'b1;
    repeat (3) @(posedge i_clock);
    o_ale_sel <= 1'b0;
    release_bus(a, o_data);
  endtask
endmodule // hbsd_host_model
`default_nettype wire

// *** testbench/hbsd_top_props.sv ***
// Purpose: Port checks of the host strobe decoder
// Assumes: Straps change only while reset is low
// Notes:   Bound to hbsd_top after the module
`timescale 1ns/1ps
`default_nettype none
`include "hbsd_consts.svh"
module hbsd_top_props (
  // Clock, reset and APB
  input wire logic        i_clock,
  input wire logic        i_rst_b,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [7:0]  i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic        o_pready,
  // Host side
  input wire logic        i_cs_n,
  input wire logic        i_bus_topology_strap,
  input wire logic        o_ready,
  input wire logic        o_ready_oe,
  input wire logic        o_int,
  // Core side
  input wire logic [15:0] o_reg_wdata,
  input wire logic        o_reg_wide,
  input wire logic        o_reg_wr,
  input wire logic        o_reg_rd,
  input wire logic        i_core_busy
);
  logic       pol_reg, edge_reg, mask_reg;
  logic [3:0] age_reg, csh_reg;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  // Mirror of control and mask writes, with cycles since the last one
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      {edge_reg, pol_reg, mask_reg} <= 3'h0;
      age_reg <= 4'h0;
    end else if (i_psel && i_penable && o_pready && i_pwrite && i_paddr == `HBSD_OFF_CTRL) begin
      {edge_reg, pol_reg} <= i_pwdata[1:0];
      age_reg <= 4'h0;
    end else if (i_psel && i_penable && o_pready && i_pwrite && i_paddr == `HBSD_OFF_MASK) begin
      mask_reg <= |i_pwdata[3:0];
      age_reg <= 4'h0;
    end else begin
      age_reg <= age_reg + {3'h0, age_reg != 4'hf};
    end
  end
  // Length of the current chip select idle run
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      csh_reg <= 4'h0;
    end else begin
      csh_reg <= i_cs_n ? csh_reg + {3'h0, csh_reg != 4'hf} : 4'h0;
    end
  end
  // Request pulse, pulse start and pulse body
  sequence s_req;
    (o_reg_wr || o_reg_rd) && o_ready_oe;
  endsequence
  sequence s_int_on;
    edge_reg && age_reg == 4'hf && o_int == pol_reg && $past(o_int) != pol_reg;
  endsequence
  sequence s_pulse;
    (o_int == pol_reg) [*8] ##1 (o_int != pol_reg);
  endsequence
  no_cs_req_a: assert property (o_reg_wr || o_reg_rd |-> csh_reg < 4'h8)
    else $error("request pulse while chip select idle");
  ready_hold_a: assert property (s_req |-> !o_ready [*6])
    else $error("ready high too soon after a request");
  busy_ready_a: assert property (o_ready_oe && i_core_busy |=> !o_ready)
    else $error("ready high while core busy");
  oe_topo_a: assert property (o_ready_oe |-> i_bus_topology_strap == `HBSD_TOPO_GENERIC)
    else $error("ready driven in split topology");
  wide_topo_a: assert property (o_reg_wr |-> o_reg_wide == (i_bus_topology_strap == `HBSD_TOPO_GENERIC))
    else $error("write width does not follow topology");
  split_zext_a: assert property (o_reg_wr && !o_reg_wide |-> o_reg_wdata[15:8] == 8'h00)
    else $error("narrow write data not zero extended");
  int_pulse_a: assert property (s_int_on |-> s_pulse)
    else $error("interrupt pulse width wrong");
  int_idle_a: assert property (!mask_reg && age_reg == 4'hf |-> o_int != pol_reg)
    else $error("interrupt active with all sources masked");
endmodule // hbsd_top_props
bind hbsd_top hbsd_top_props u_props (
  .i_clock(i_clock), .i_rst_b(i_rst_b), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready), .i_cs_n(i_cs_n),
  .i_bus_topology_strap(i_bus_topology_strap), .o_ready(o_ready), .o_ready_oe(o_ready_oe), .o_int(o_int),
  .o_reg_wdata(o_reg_wdata), .o_reg_wide(o_reg_wide), .o_reg_wr(o_reg_wr), .o_reg_rd(o_reg_rd),
  .i_core_busy(i_core_busy));
`default_nettype wire

// *** testbench/host_bus_strobe_decode_tb.sv ***
// Purpose: Self-checking bench of the host strobe decoder
// Assumes: 200 MHz clock; straps change only in reset
// Notes:   Random values from a bench LFSR with a fixed seed
`timescale 1ns/1ps
`default_nettype none
`include "hbsd_consts.svh"
module host_bus_strobe_decode_tb;
  // Pins and bench state
  logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, late, qe;
  logic        cs_n, dir_rd_n, strobe_wr_n, ale_sel, ready, ready_oe, int_pin;
  logic        sty, pha, topo, reg_wide, reg_wr, reg_rd, core_busy, core_irq;
  logic [7:0]  paddr, ad, reg_addr;
  logic [15:0] data, reg_wdata;
  logic [31:0] pwdata, prdata, q, lfsr, last_wr;
  int          mismatches = 0, comparisons = 0, wr_cnt = 0, rd_cnt = 0, n0;
  wire         rdy = ready_oe ? ready : 1'b1;
  // Design and host model
  hbsd_top uut (
    .i_clock(clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_cs_n(cs_n), .i_dir_rd_n(dir_rd_n), .i_data_strobe_wr_n(strobe_wr_n), .i_ale_addr_data_select(ale_sel),
    .i_ad(ad), .i_data(data), .i_ready_in(1'b1), .o_ready(ready), .o_ready_oe(ready_oe), .o_int(int_pin),
    .i_strobe_style_strap(sty), .i_address_phase_strap(pha), .i_bus_topology_strap(topo),
    .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata), .o_reg_wide(reg_wide), .o_reg_wr(reg_wr),
    .o_reg_rd(reg_rd), .i_core_busy(core_busy), .i_core_irq(core_irq));
  hbsd_host_model u_host (
    .i_clock(clk), .i_ready(rdy), .o_cs_n(cs_n), .o_dir_rd_n(dir_rd_n), .o_strobe_wr_n(strobe_wr_n),
    .o_ale_sel(ale_sel), .o_ad(ad), .o_data(data), .o_late(late));
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Count and record core-side request pulses
  always @(posedge clk) begin
    if (reg_wr === 1'b1) begin
      wr_cnt  = wr_cnt + 1;
      last_wr = {7'h0, reg_wide, reg_addr, reg_wdata};
    end
    if (reg_rd === 1'b1) rd_cnt = rd_cnt + 1;
  end
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected record of one data write
  function automatic logic [31:0] exp_wr(input logic wide, input logic [7:0] a, input logic [15:0] d);
    return {7'h0, wide, a, wide ? d : {8'h00, d[7:0]}};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  // One APB transfer, pready waited for under a bound
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    qe = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      mismatches++;
      results();
    end
  endtask
  task automatic host(input logic cs, input logic rd, input logic sel, input logic [7:0] a, input logic [15:0] d);
    n0 = rd ? rd_cnt : wr_cnt;
    u_host.acc(cs, rd, sty, sel, a, d);
    repeat (2) @(posedge clk);
  endtask
  // Reset with straps {topology, phase, style}
  task automatic boot(input logic [2:0] s);
    @(posedge clk);
    rst_b <= 1'b0;
    {topo, pha, sty} <= s;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
    apb(1'b0, `HBSD_OFF_STRAPS, 32'h0);
    chk(q, {29'h0, s});
  endtask
  task automatic results();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    {rst_b, psel, penable, pwrite, paddr, pwdata, core_busy, core_irq} = '0;
    {topo, pha, sty} = 3'h7;
    lfsr = 32'h38bed325;
    boot(3'h7);
    apb(1'b0, `HBSD_OFF_CTRL, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chkb(qe, 1'b1);
    for (int i = 0; i < 6; i++) begin
      lfsr = lfsr_next(lfsr);
      host(1'b0, 1'b0, lfsr[24], lfsr[7:0], lfsr[23:8]);
      chk(wr_cnt - n0, 32'h1);
      chk(last_wr, exp_wr(1'b1, lfsr[7:0], lfsr[23:8]));
      host(1'b0, 1'b1, 1'b0, lfsr[15:8], 16'h0);
      chk(rd_cnt - n0, 32'h1);
      chk({24'h0, reg_addr}, {24'h0, lfsr[15:8]});
    end
    host(1'b1, 1'b0, 1'b0, 8'h5a, 16'ha5a5);
    chk(wr_cnt - n0, 32'h0);
    $display("test generic strobes done");
    apb(1'b1, `HBSD_OFF_STATUS, 32'hf);
    apb(1'b1, `HBSD_OFF_MASK, 32'h2);
    apb(1'b1, `HBSD_OFF_CTRL, 32'h1);
    repeat (16) @(posedge clk);
    chkb(int_pin, 1'b0);
    host(1'b0, 1'b0, 1'b0, 8'h11, 16'h2222);
    chkb(int_pin, 1'b1);
    apb(1'b1, `HBSD_OFF_STATUS, 32'h2);
    repeat (4) @(posedge clk);
    chkb(int_pin, 1'b0);
    apb(1'b1, `HBSD_OFF_MASK, 32'h0);
    host(1'b0, 1'b0, 1'b0, 8'h12, 16'h3333);
    chkb(int_pin, 1'b0);
    apb(1'b1, `HBSD_OFF_MASK, 32'h8);
    apb(1'b1, `HBSD_OFF_CTRL, 32'h2);
    repeat (17) @(posedge clk);
    core_irq <= 1'b1;
    @(posedge clk);
    core_irq <= 1'b0;
    repeat (4) @(posedge clk);
    chkb(int_pin, 1'b0);
    repeat (12) @(posedge clk);
    chkb(int_pin, 1'b1);
    core_busy <= 1'b1;
    repeat (10) @(posedge clk);
    chkb(ready, 1'b0);
    core_busy <= 1'b0;
    repeat (3) @(posedge clk);
    chkb(ready, 1'b1);
    $display("test interrupt and ready done");
    boot(3'h4);
    host(1'b0, 1'b0, 1'b0, lfsr[7:0], lfsr[31:16]);
    chk(last_wr, exp_wr(1'b1, lfsr[7:0], lfsr[31:16]));
    host(1'b0, 1'b1, 1'b0, lfsr[7:0], 16'h0);
    chk(rd_cnt - n0, 32'h1);
    $display("test direction strobe done");
    boot(3'h2);
    lfsr = lfsr_next(lfsr);
    host(1'b0, 1'b0, 1'b1, lfsr[7:0], lfsr[31:16]);
    chk(wr_cnt - n0, 32'h0);
    apb(1'b0, `HBSD_OFF_ADDR, 32'h0);
    chk(q, {24'h0, lfsr[7:0]});
    host(1'b0, 1'b0, 1'b0, lfsr[15:8], lfsr[31:16]);
    chk(last_wr, exp_wr(1'b0, lfsr[7:0], {8'h00, lfsr[15:8]}));
    $display("test split select done");
    boot(3'h1);
    lfsr = lfsr_next(lfsr);
    u_host.ale(lfsr[7:0]);
    host(1'b0, 1'b0, 1'b0, lfsr[15:8], lfsr[31:16]);
    chk(last_wr, exp_wr(1'b0, lfsr[7:0], {8'h00, lfsr[15:8]}));
    $display("test split latch done");
    chkb(late, 1'b0);
    results();
  end
endmodule // host_bus_strobe_decode_tb
`default_nettype wire
